// ---- verilog/lsx_regs.svh ----
// lsx_regs.svh: instruction lengths, clock counts and field constants of the
// logic, shift and rotate execution unit.
// assumes: included by bare name from the package only; the unit relies on its macros.
`ifndef LSX_REGS_SVH
`define LSX_REGS_SVH

// clock period in ns
`define LSX_CLK_NS 50

// instruction lengths in bytes
`define LSX_LEN_2 4'h2
`define LSX_LEN_3 4'h3
`define LSX_LEN_4 4'h4
`define LSX_LEN_5 4'h5
`define LSX_LEN_6 4'h6

// execution times in clocks
`define LSX_CLK_REG 6'h03
`define LSX_CLK_IND 6'h04
`define LSX_CLK_INC 6'h05
`define LSX_CLK_OFF 6'h06
`define LSX_CLK_DIR 6'h04
`define LSX_CLK_IMM_REG 6'h03
`define LSX_CLK_IMM_IND 6'h04
`define LSX_CLK_IMM_INC 6'h05
`define LSX_CLK_IMM_OFF 6'h06
`define LSX_CLK_IMM_DIR 6'h04
// shift family: base clocks plus one clock per shift
`define LSX_CLK_SHIFT_BASE 6'h03

// field layout
`define LSX_CNT_W 5
`define LSX_NIB_W 4
`define LSX_BYTE_MASK 16'h00ff
`define LSX_OFF8_MASK 16'h00ff
`define LSX_INC_BYTE 16'h0001
`define LSX_INC_WORD 16'h0002
// memory data is captured this many cycles after the read strobe is taken
`define LSX_RD_CAPTURE 6'h02

`endif

// ---- verilog/lsx_pkg.sv ----
// lsx_pkg: operation and operand-form types of the execution unit.
// assumes: lsx_regs.svh is on the include path.
`default_nettype none
package lsx_pkg;
`include "lsx_regs.svh"

    typedef enum logic [3:0] {
        op_and,
        op_or,
        op_xor,
        ones_complement_op,
        logical_right_shift_op,
        normalize_left_op,
        rotate_left_op,
        rotate_right_op,
        rotate_left_carry_op,
        rotate_right_carry_op
    } lsx_op_t;

    typedef enum logic [4:0] {
        m_reg_reg,
        m_reg_ind,
        m_ind_reg,
        m_reg_off8,
        m_off8_reg,
        m_reg_off16,
        m_off16_reg,
        m_reg_inc,
        m_inc_reg,
        m_dir_reg,
        m_reg_dir,
        m_reg_imm,
        m_ind_imm,
        m_inc_imm,
        m_off8_imm,
        m_off16_imm,
        m_dir_imm
    } lsx_mode_t;

endpackage
`default_nettype wire

// ---- verilog/lsx_exec.sv ----
// lsx_exec: executes logical, complement, shift, normalize and rotate
// instructions, logical ones in every operand form, with fixed length and clock count (shift clocks add the count).
// assumes: decoder holds operands valid with start; memory answers a read
// strobe with data on mem_rdata one cycle later; one core clock.
// Function
// - register combined with memory via source pointer: 2 bytes, 4 clocks
// - register combined into memory via destination pointer: 2 bytes, 4 clocks
// - pointer plus unsigned 8-bit offset forms: 3 bytes, 6 clocks
// - pointer plus 16-bit offset forms: 4 bytes, 6 clocks
// - post-increment pointer forms: 2 bytes, 5 clocks, pointer updated
// - direct memory with register, either direction: 3 bytes, 4 clocks
// - immediate to register: 3 clocks, 3 or 4 bytes by constant size
// - immediate to pointer memory: 4 clocks, 3 or 4 bytes
// - immediate via post-increment pointer: 5 clocks, 3 or 4 bytes
// - immediate to pointer plus 8-bit offset: 6 clocks, 4 or 5 bytes
// - immediate to pointer plus 16-bit offset: 6 clocks, 5 or 6 bytes
// - immediate to direct memory: 4 clocks, 4 or 5 bytes
// - logical right shift by source register count, zero fill, 2 bytes
// - logical right shift by 4-bit constant count, 2 bytes
// - normalize shifts left until top bit set, count to source register
// - rotate left or right without carry by 4-bit constant, 2 bytes
// - rotate left or right through carry by 4-bit constant, 2 bytes
`timescale 1ns/10ps
`default_nettype none
module lsx_exec
    import lsx_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter logic [5:0] SHIFT_BASE = `LSX_CLK_SHIFT_BASE
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire lsx_op_t op,
    input wire lsx_mode_t mode,
    input wire logic word,
    input wire logic [15:0] dst_val,
    input wire logic [15:0] src_val,
    input wire logic [15:0] imm_word,
    input wire logic [15:0] disp,
    input wire logic [15:0] direct_addr,
    input wire logic carry_in,
    input wire logic [15:0] mem_rdata,
    output logic busy_q,
    output logic done_q,
    output logic illegal_q,
    output logic [3:0] len_q,
    output logic [5:0] clocks_q,
    output logic mem_rd_q,
    output logic mem_wr_q,
    output logic mem_word_q,
    output logic [15:0] mem_addr_q,
    output logic [15:0] mem_wdata_q,
    output logic dst_wr_q,
    output logic [15:0] dst_wdata_q,
    output logic src_wr_q,
    output logic [15:0] src_wdata_q,
    output logic ptr_wr_q,
    output logic ptr_is_src_q,
    output logic [15:0] ptr_wdata_q,
    output logic carry_wr_q,
    output logic carry_out_q
);

    if (DATA_W != 16 || SHIFT_BASE < 6'h02 || SHIFT_BASE > 6'h20)
        $error("lsx_exec needs a 16-bit data path and a shift base of 2 to 32");

    function automatic logic is_shift(input lsx_op_t o);
        is_shift = o inside {logical_right_shift_op, normalize_left_op, rotate_left_op,
                             rotate_right_op, rotate_left_carry_op, rotate_right_carry_op};
    endfunction

    // forms that write memory rather than the destination register
    function automatic logic mem_dest(input lsx_mode_t m);
        mem_dest = m inside {m_ind_reg, m_off8_reg, m_off16_reg, m_inc_reg, m_dir_reg,
                             m_ind_imm, m_inc_imm, m_off8_imm, m_off16_imm, m_dir_imm};
    endfunction

    function automatic logic mem_src(input lsx_mode_t m);
        mem_src = (m == m_reg_ind) || (m == m_reg_off8) || (m == m_reg_off16) ||
                  (m == m_reg_inc) || (m == m_reg_dir);
    endfunction

    function automatic logic [3:0] len_of(input lsx_op_t o, input lsx_mode_t m,
                                          input logic w);
        logic [3:0] l;
        case (m)
            m_reg_off8, m_off8_reg, m_reg_dir, m_dir_reg: l = `LSX_LEN_3;
            m_reg_off16, m_off16_reg: l = `LSX_LEN_4;
            m_reg_imm, m_ind_imm, m_inc_imm: l = w ? `LSX_LEN_4 : `LSX_LEN_3;
            m_off8_imm, m_dir_imm: l = w ? `LSX_LEN_5 : `LSX_LEN_4;
            m_off16_imm: l = w ? `LSX_LEN_6 : `LSX_LEN_5;
            default: l = `LSX_LEN_2;
        endcase
        if (is_shift(o) || (o == ones_complement_op))
            l = `LSX_LEN_2;
        len_of = l;
    endfunction

    function automatic logic [5:0] clk_of(input lsx_op_t o, input lsx_mode_t m,
                                          input logic [4:0] n);
        logic [5:0] c;
        case (m)
            m_reg_ind, m_ind_reg: c = `LSX_CLK_IND;
            m_reg_off8, m_off8_reg, m_reg_off16, m_off16_reg: c = `LSX_CLK_OFF;
            m_reg_inc, m_inc_reg: c = `LSX_CLK_INC;
            m_reg_dir, m_dir_reg: c = `LSX_CLK_DIR;
            m_reg_imm: c = `LSX_CLK_IMM_REG;
            m_ind_imm: c = `LSX_CLK_IMM_IND;
            m_inc_imm: c = `LSX_CLK_IMM_INC;
            m_off8_imm, m_off16_imm: c = `LSX_CLK_IMM_OFF;
            m_dir_imm: c = `LSX_CLK_IMM_DIR;
            default: c = `LSX_CLK_REG;
        endcase
        if (is_shift(o))
            c = SHIFT_BASE + {1'b0, n};
        clk_of = c;
    endfunction

    // leading zeros of the operand at its size; zero operand gives zero
    function automatic logic [4:0] lead_zeros(input logic [15:0] v, input logic w);
        logic [4:0] z;
        logic hit;
        z = 5'h00;
        hit = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            hit = hit || (v[i] && (w || (i < 8)));
            if (!hit && (w || (i < 8)))
                z = z + 5'h01;
        end
        lead_zeros = hit ? z : 5'h00;
    endfunction

    // rotate of {carry, value} by n steps at the operand size
    function automatic logic [16:0] rot(input logic [15:0] v, input logic c,
                                        input logic [3:0] n, input logic w,
                                        input logic left, input logic thru);
        logic [15:0] x;
        logic cy;
        logic spill;
        x = v;
        cy = c;
        for (int i = 0; i < 15; i++)
        begin
            if (i < n)
            begin
                // bit leaving the operand this step, taken before the shift
                spill = left ? (w ? x[15] : x[7]) : x[0];
                if (left)
                    x = {x[14:0], thru ? cy : spill};
                else if (w)
                    x = {thru ? cy : spill, x[15:1]};
                else
                    x = {8'h00, thru ? cy : spill, x[7:1]};
                if (thru)
                    cy = spill;
                if (!w)
                    x = x & `LSX_BYTE_MASK;
            end
        end
        rot = {cy, x};
    endfunction

    logic legal;
    logic [4:0] cnt_in;
    logic [15:0] ptr_in;
    logic [15:0] addr_in;
    always_comb
    begin
        legal = 1'b1;
        if (op == ones_complement_op || op == normalize_left_op)
            legal = (mode == m_reg_reg);
        else if (op == logical_right_shift_op)
            legal = (mode == m_reg_reg) || (mode == m_reg_imm);
        else if (is_shift(op))
            legal = (mode == m_reg_imm);
        // count: leading zeros for normalize, register for register-form shift, constant nibble otherwise
        if (op == normalize_left_op)
            cnt_in = lead_zeros(dst_val, word);
        else if (op == logical_right_shift_op && mode == m_reg_reg)
            cnt_in = src_val[`LSX_CNT_W-1:0];
        else
            cnt_in = {1'b0, imm_word[`LSX_NIB_W-1:0]};
        ptr_in = mem_dest(mode) ? dst_val : src_val;
        if (mode == m_reg_off8 || mode == m_off8_reg || mode == m_off8_imm)
            addr_in = ptr_in + (disp & `LSX_OFF8_MASK);
        else if (mode == m_reg_off16 || mode == m_off16_reg || mode == m_off16_imm)
            addr_in = ptr_in + disp;
        else if (mode == m_reg_dir || mode == m_dir_reg || mode == m_dir_imm)
            addr_in = direct_addr;
        else
            addr_in = ptr_in;
    end

    wire logic take = start && !busy_q;
    lsx_op_t op_q;
    lsx_mode_t mode_q;
    logic word_q;
    logic carry_q;
    logic [4:0] cnt_q;
    logic [5:0] left_q;
    logic [5:0] age_q;
    logic [15:0] a_q;
    logic [15:0] b_q;

    // instruction capture and cycle count
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            busy_q <= 1'b0;
            illegal_q <= 1'b0;
            len_q <= 4'h0;
            clocks_q <= 6'h00;
            left_q <= 6'h00;
            age_q <= 6'h00;
            op_q <= op_and;
            mode_q <= m_reg_reg;
            word_q <= 1'b0;
            carry_q <= 1'b0;
            cnt_q <= 5'h00;
            a_q <= 16'h0000;
            b_q <= 16'h0000;
        end
        else
        begin
            illegal_q <= take && !legal;
            if (take && legal)
            begin
                busy_q <= 1'b1;
                len_q <= len_of(op, mode, word);
                clocks_q <= clk_of(op, mode, cnt_in);
                left_q <= clk_of(op, mode, cnt_in) - 6'h01;
                age_q <= 6'h00;
                op_q <= op;
                mode_q <= mode;
                word_q <= word;
                carry_q <= carry_in;
                cnt_q <= cnt_in;
                a_q <= mem_dest(mode) ? 16'h0000 : dst_val;
                b_q <= (mode >= m_reg_imm) ? imm_word : src_val;
            end
            else if (busy_q)
            begin
                left_q <= left_q - 6'h01;
                age_q <= age_q + 6'h01;
                // memory operand arrives one cycle after the strobe
                if (age_q == `LSX_RD_CAPTURE - 6'h01 && mem_dest(mode_q))
                    a_q <= mem_rdata;
                if (age_q == `LSX_RD_CAPTURE - 6'h01 && mem_src(mode_q))
                    b_q <= mem_rdata;
                if (left_q == 6'h01)
                    busy_q <= 1'b0;
            end
        end
    end

    // memory read strobe and address
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mem_rd_q <= 1'b0;
            mem_word_q <= 1'b0;
            mem_addr_q <= 16'h0000;
        end
        else
        begin
            mem_rd_q <= take && legal && (mem_dest(mode) || mem_src(mode));
            if (take && legal)
            begin
                mem_addr_q <= addr_in;
                mem_word_q <= word;
            end
        end
    end

    logic [15:0] res;
    logic [16:0] rr;
    always_comb
    begin
        rr = rot(a_q, carry_q, cnt_q[3:0], word_q,
                 (op_q == rotate_left_op) || (op_q == rotate_left_carry_op),
                 (op_q == rotate_left_carry_op) || (op_q == rotate_right_carry_op));
        case (op_q)
            op_and: res = a_q & b_q;
            op_or: res = a_q | b_q;
            op_xor: res = a_q ^ b_q;
            ones_complement_op: res = ~a_q;
            logical_right_shift_op: res = (word_q ? a_q : (a_q & `LSX_BYTE_MASK)) >> cnt_q;
            normalize_left_op: res = a_q << cnt_q;
            default: res = rr[15:0];
        endcase
        if (!word_q)
            res = res & `LSX_BYTE_MASK;
    end

    wire logic finish = busy_q && (left_q == 6'h01);
    wire logic inc_form = mode_q inside {m_reg_inc, m_inc_reg, m_inc_imm};

    // completion: result write-back and pointer update
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            done_q <= 1'b0;
            mem_wr_q <= 1'b0;
            mem_wdata_q <= 16'h0000;
            dst_wr_q <= 1'b0;
            dst_wdata_q <= 16'h0000;
            src_wr_q <= 1'b0;
            src_wdata_q <= 16'h0000;
            ptr_wr_q <= 1'b0;
            ptr_is_src_q <= 1'b0;
            ptr_wdata_q <= 16'h0000;
            carry_wr_q <= 1'b0;
            carry_out_q <= 1'b0;
        end
        else
        begin
            done_q <= finish;
            mem_wr_q <= finish && mem_dest(mode_q);
            dst_wr_q <= finish && !mem_dest(mode_q);
            src_wr_q <= finish && (op_q == normalize_left_op);
            ptr_wr_q <= finish && inc_form;
            carry_wr_q <= finish && ((op_q == rotate_left_carry_op) ||
                                     (op_q == rotate_right_carry_op));
            if (finish)
            begin
                mem_wdata_q <= res;
                dst_wdata_q <= res;
                src_wdata_q <= {11'h000, cnt_q};
                ptr_is_src_q <= !mem_dest(mode_q);
                ptr_wdata_q <= mem_addr_q + (word_q ? `LSX_INC_WORD : `LSX_INC_BYTE);
                carry_out_q <= rr[16];
            end
        end
    end

endmodule
`default_nettype wire

// ---- verif/lsx_exec_chk.sv ----
// lsx_exec_chk: timing and strobe checks on the execution unit's ports.
// assumes: one clock, synchronous active-low reset, bound to lsx_exec.
`timescale 1ns/10ps
`default_nettype none
module lsx_exec_chk
    import lsx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire lsx_op_t op,
    input wire lsx_mode_t mode,
    input wire logic word,
    input wire logic [15:0] src_val,
    input wire logic busy_q,
    input wire logic done_q,
    input wire logic illegal_q,
    input wire logic [3:0] len_q,
    input wire logic [5:0] clocks_q,
    input wire logic mem_rd_q,
    input wire logic mem_wr_q,
    input wire logic mem_word_q,
    input wire logic [15:0] mem_addr_q,
    input wire logic dst_wr_q,
    input wire logic ptr_wr_q,
    input wire logic [15:0] ptr_wdata_q,
    input wire logic carry_wr_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic take;
    assign take = start && !busy_q;

    done_pulse_a: assert property (done_q |=> !done_q)
        else $error("done held longer than one cycle");
    take_answer_a: assert property (take |-> ##[1:2] (busy_q || illegal_q))
        else $error("taken request got no answer");
    imm_reg_a: assert property (take && op == op_or && mode == m_reg_imm |=>
        len_q == ($past(word) ? 4'h4 : 4'h3) ##2 (done_q && dst_wr_q))
        else $error("immediate to register length or timing off");
    ind_read_a: assert property (take && op == op_and && mode == m_reg_ind |=>
        (mem_rd_q && mem_addr_q == $past(src_val)) ##3 done_q)
        else $error("indirect read address or timing off");
    dir_imm_a: assert property (take && op == op_xor && mode == m_dir_imm |=>
        clocks_q == 6'h04 && len_q == ($past(word) ? 4'h5 : 4'h4))
        else $error("direct immediate length or clocks off");
    off16_dst_a: assert property (take && op == op_and && mode == m_off16_reg |=>
        (clocks_q == 6'h06 && len_q == 4'h4) ##5 (done_q && mem_wr_q))
        else $error("offset16 destination timing off");
    wr_done_a: assert property (mem_wr_q |-> done_q)
        else $error("memory write outside completion");
    inc_ptr_a: assert property (ptr_wr_q |-> done_q &&
        ptr_wdata_q == mem_addr_q + (mem_word_q ? 16'h0002 : 16'h0001))
        else $error("pointer update value wrong");
    carry_done_a: assert property (carry_wr_q |-> done_q)
        else $error("carry write outside completion");
endmodule

bind lsx_exec lsx_exec_chk chk_u (.clk(clk), .rst_n(rst_n), .start(start), .op(op),
    .mode(mode), .word(word), .src_val(src_val), .busy_q(busy_q), .done_q(done_q),
    .illegal_q(illegal_q), .len_q(len_q), .clocks_q(clocks_q), .mem_rd_q(mem_rd_q),
    .mem_wr_q(mem_wr_q), .mem_word_q(mem_word_q), .mem_addr_q(mem_addr_q),
    .dst_wr_q(dst_wr_q), .ptr_wr_q(ptr_wr_q), .ptr_wdata_q(ptr_wdata_q),
    .carry_wr_q(carry_wr_q));
`default_nettype wire

// ---- verif/lsx_mem_model.sv ----
// lsx_mem_model: data memory answering a read strobe one cycle later.
// assumes: read data is a fixed scramble of the address.
`timescale 1ns/10ps
`default_nettype none
module lsx_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mem_rd_q,
    input wire logic [15:0] mem_addr_q,
    output logic [15:0] mem_rdata
);
    // outside a read the bus shows the inverse so stale data is never captured
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            mem_rdata <= 16'h0000;
        else if (mem_rd_q)
            mem_rdata <= mem_addr_q ^ 16'h5a5a;
        else
            mem_rdata <= ~mem_rdata;
    end
endmodule
`default_nettype wire

// ---- verif/test_logic_shift_rotate_exec_timing.sv ----
// test_logic_shift_rotate_exec_timing: self-checking bench of lsx_exec.
// assumes: lsx_mem_model answers reads; 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module test_logic_shift_rotate_exec_timing;
    import lsx_pkg::*;
    localparam logic [5:0] BASE = 6'h03;
    logic clk, rst_n, start, word, carry_in, busy_q, done_q, illegal_q, mem_rd_q, mem_wr_q;
    logic mem_word_q, dst_wr_q, src_wr_q, ptr_wr_q, ptr_is_src_q, carry_wr_q, carry_out_q;
    lsx_op_t op;
    lsx_mode_t mode;
    logic [3:0] len_q;
    logic [5:0] clocks_q;
    logic [15:0] dst_val, src_val, imm_word, disp, direct_addr, mem_rdata, mem_addr_q;
    logic [15:0] mem_wdata_q, dst_wdata_q, src_wdata_q, ptr_wdata_q;
    int failures = 0;
    int n_checks = 0;

    lsx_exec #(.DATA_W(16), .SHIFT_BASE(BASE)) dut_u (.clk(clk), .rst_n(rst_n),
        .start(start), .op(op), .mode(mode), .word(word), .dst_val(dst_val),
        .src_val(src_val), .imm_word(imm_word), .disp(disp), .direct_addr(direct_addr),
        .carry_in(carry_in), .mem_rdata(mem_rdata), .busy_q(busy_q), .done_q(done_q),
        .illegal_q(illegal_q), .len_q(len_q), .clocks_q(clocks_q), .mem_rd_q(mem_rd_q),
        .mem_wr_q(mem_wr_q), .mem_word_q(mem_word_q), .mem_addr_q(mem_addr_q),
        .mem_wdata_q(mem_wdata_q), .dst_wr_q(dst_wr_q), .dst_wdata_q(dst_wdata_q),
        .src_wr_q(src_wr_q), .src_wdata_q(src_wdata_q), .ptr_wr_q(ptr_wr_q),
        .ptr_is_src_q(ptr_is_src_q), .ptr_wdata_q(ptr_wdata_q), .carry_wr_q(carry_wr_q),
        .carry_out_q(carry_out_q));
    lsx_mem_model mem_u (.clk(clk), .rst_n(rst_n), .mem_rd_q(mem_rd_q),
        .mem_addr_q(mem_addr_q), .mem_rdata(mem_rdata));

    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // one instruction; returns in the completion cycle; el of zero means refused
    task automatic run(input lsx_op_t o, input lsx_mode_t m, input logic w,
        input logic [15:0] d, input logic [15:0] s, input logic [15:0] im,
        input logic [15:0] ds, input logic c, input logic [5:0] ec, input logic [3:0] el);
        int n;
        op = o;
        mode = m;
        word = w;
        dst_val = d;
        src_val = s;
        imm_word = im;
        disp = ds;
        direct_addr = ds ^ 16'h0f00;
        carry_in = c;
        start = 1'h1;
        @(posedge clk);
        #1;
        start = 1'h0;
        n = 1;
        while (done_q !== 1'h1 && illegal_q !== 1'h1 && n < 40)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (el != 4'h0)
        begin
            chk("clocks taken", 16'(ec), 16'(n));
            chk("clocks_q", 16'(ec), 16'(clocks_q));
            chk("len_q", 16'(el), 16'(len_q));
        end
        else
            chk("illegal_q", 16'h0001, 16'(illegal_q));
    endtask

    function automatic logic [5:0] eclk(lsx_mode_t m);
        case (m)
            m_reg_reg, m_reg_imm: return 6'h03;
            m_reg_ind, m_ind_reg, m_ind_imm: return 6'h04;
            m_reg_inc, m_inc_reg, m_inc_imm: return 6'h05;
            m_dir_reg, m_reg_dir, m_dir_imm: return 6'h04;
            default: return 6'h06;
        endcase
    endfunction

    function automatic logic [3:0] elen(lsx_mode_t m, logic w);
        case (m)
            m_reg_reg, m_reg_ind, m_ind_reg, m_reg_inc, m_inc_reg: return 4'h2;
            m_reg_off8, m_off8_reg, m_dir_reg, m_reg_dir: return 4'h3;
            m_reg_off16, m_off16_reg: return 4'h4;
            m_off8_imm, m_dir_imm: return w ? 4'h5 : 4'h4;
            m_off16_imm: return w ? 4'h6 : 4'h5;
            default: return w ? 4'h4 : 4'h3;
        endcase
    endfunction

    // every operand form of and, or, xor in both sizes, back to back
    task automatic test_forms();
        for (int i = 0; i < 17; i++)
            for (int w = 0; w < 2; w++)
                for (int k = 0; k < 3; k++)
                    run(lsx_op_t'(k), lsx_mode_t'(i), w[0], 16'h5555, 16'h0a0a, 16'h00c3,
                        16'h0040, 1'h0, eclk(lsx_mode_t'(i)), elen(lsx_mode_t'(i), w[0]));
    endtask

    task automatic test_data();
        run(op_and, m_reg_ind, 1'h1, 16'h0ff0, 16'h1234, 16'h0, 16'h0, 1'h0, 6'h04, 4'h2);
        chk("dst_wdata", 16'h0860, dst_wdata_q);
        run(op_xor, m_off8_reg, 1'h0, 16'h0100, 16'h0f0f, 16'h0, 16'h12ff, 1'h0, 6'h06, 4'h3);
        chk("mem_addr", 16'h01ff, mem_addr_q);
        chk("mem_wdata", 16'h00aa, mem_wdata_q);
        chk("mem_wr", 16'h0001, 16'(mem_wr_q));
        run(op_and, m_reg_inc, 1'h1, 16'hffff, 16'h2000, 16'h0, 16'h0, 1'h0, 6'h05, 4'h2);
        chk("ptr_wdata src", 16'h2002, ptr_wdata_q);
        chk("ptr_is_src", 16'h0001, 16'(ptr_is_src_q));
        chk("dst_wdata inc", 16'h7a5a, dst_wdata_q);
        run(op_or, m_inc_reg, 1'h0, 16'h3000, 16'h0011, 16'h0, 16'h0, 1'h0, 6'h05, 4'h2);
        chk("ptr_wdata dst", 16'h3001, ptr_wdata_q);
        chk("ptr_wr", 16'h0001, 16'({ptr_wr_q, ptr_is_src_q} == 2'h2));
        run(op_xor, m_reg_imm, 1'h0, 16'h1234, 16'h0, 16'h00ff, 16'h0, 1'h0, 6'h03, 4'h3);
        chk("imm byte result", 16'h00cb, dst_wdata_q);
    endtask

    task automatic test_shift();
        run(logical_right_shift_op, m_reg_reg, 1'h1, 16'h8000, 16'h0005, 16'h0, 16'h0, 1'h0,
            BASE + 6'h05, 4'h2);
        chk("shift reg count", 16'h0400, dst_wdata_q);
        run(logical_right_shift_op, m_reg_imm, 1'h0, 16'h00f0, 16'h0, 16'h0004, 16'h0, 1'h0,
            BASE + 6'h04, 4'h2);
        chk("shift nibble count", 16'h000f, dst_wdata_q);
        run(normalize_left_op, m_reg_reg, 1'h1, 16'h0010, 16'h0, 16'h0, 16'h0, 1'h0,
            BASE + 6'h0b, 4'h2);
        chk("normalized", 16'h8000, dst_wdata_q);
        chk("normalize count", 16'h000b, src_wr_q ? src_wdata_q : 16'hdead);
        run(rotate_left_op, m_reg_imm, 1'h1, 16'h8001, 16'h0, 16'h0001, 16'h0, 1'h1,
            BASE + 6'h01, 4'h2);
        chk("rotate left", 16'h0003, dst_wdata_q);
        run(rotate_right_op, m_reg_imm, 1'h0, 16'h0081, 16'h0, 16'h0001, 16'h0, 1'h1,
            BASE + 6'h01, 4'h2);
        chk("rotate right", 16'h00c0, dst_wdata_q);
        run(rotate_left_carry_op, m_reg_imm, 1'h1, 16'h8000, 16'h0, 16'h0001, 16'h0, 1'h0,
            BASE + 6'h01, 4'h2);
        chk("rotate left carry", 16'h0000, dst_wdata_q);
        chk("carry out left", 16'h0003, 16'({carry_wr_q, carry_out_q}));
        run(rotate_right_carry_op, m_reg_imm, 1'h0, 16'h0001, 16'h0, 16'h0001, 16'h0, 1'h1,
            BASE + 6'h01, 4'h2);
        chk("rotate right carry", 16'h0080, dst_wdata_q);
        chk("carry out right", 16'h0003, 16'({carry_wr_q, carry_out_q}));
        run(rotate_right_carry_op, m_reg_imm, 1'h0, 16'h0006, 16'h0, 16'h0002, 16'h0, 1'h1,
            BASE + 6'h02, 4'h2);
        chk("rotate right carry 2", 16'h0041, dst_wdata_q);
        chk("carry out right 2", 16'h0003, 16'({carry_wr_q, carry_out_q}));
        run(ones_complement_op, m_reg_reg, 1'h1, 16'h00ff, 16'h0, 16'h0, 16'h0, 1'h0,
            6'h03, 4'h2);
        chk("complement", 16'hff00, dst_wdata_q);
    endtask

    // forms outside the legal table are refused with no completion
    task automatic test_refuse();
        run(ones_complement_op, m_reg_ind, 1'h1, 16'h0, 16'h0, 16'h0, 16'h0, 1'h0, 6'h0, 4'h0);
        chk("refused done", 16'h0000, 16'(done_q));
        run(rotate_left_op, m_reg_reg, 1'h1, 16'h0, 16'h0, 16'h0, 16'h0, 1'h0, 6'h0, 4'h0);
        chk("refused write", 16'h0000, 16'(dst_wr_q));
        repeat (3) @(posedge clk);
    endtask

    initial
    begin
        #(4000 * 50);
        failures++;
        stop_test();
    end

    initial
    begin
        rst_n = 1'h0;
        start = 1'h0;
        op = op_and;
        mode = m_reg_reg;
        word = 1'h0;
        dst_val = 16'h0;
        src_val = 16'h0;
        imm_word = 16'h0;
        disp = 16'h0;
        direct_addr = 16'h0;
        carry_in = 1'h0;
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'h1;
        chk("busy after reset", 16'h0000, 16'(busy_q));
        test_forms();
        test_data();
        test_shift();
        test_refuse();
        stop_test();
    end
endmodule
`default_nettype wire
